// ### rtl/sync_event_status_counters.sv
// Sync event counters, elapsed-time since last input trigger, and status stamp
// Operation
// - Count input trigger rising edges in a 32-bit tally.
// - With append flag set, stamp each async packet with the input tally.
// - Keep 32-bit microseconds elapsed since the latest input trigger.
// - With append flag set, timestamp packets relative to the last pulse.
// - Count generated output trigger events in a 32-bit tally.
// - Writing zero clears a tally; nonzero writes leave it unchanged.
// - Elapsed-time value is read-only; writes never change it.
// - Factory restore sets the async output rate to 40 Hz.
// - Restore loads factory settings; save copies settings to flash.
`timescale 1ns/100ps
`include "sync_status_regs.svh"
module sync_event_status_counters #(
  parameter int unsigned CLK_HZ = `CLK_FREQ_HZ
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Trigger pins
  input wire logic trigger_input_pin,
  input wire logic out_event_fire,
  output logic trigger_output_pin,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Settings
  input wire logic append_status_set,
  input wire logic [15:0] async_rate_set,
  input wire logic settings_wr,
  input wire logic restore_cmd,
  input wire logic save_cmd,
  output logic append_status_flag,
  output logic [15:0] async_rate_hz,
  // Flash store port
  output logic flash_save_pulse,
  output logic flash_append_status,
  output logic [15:0] flash_async_rate,
  // Async packet stamp
  input wire logic packet_start,
  output logic stamp_valid,
  output logic [31:0] stamp_in_tally,
  output logic [31:0] stamp_since_us
);
  localparam int unsigned US_CYCLES = CLK_HZ / `US_PER_S;
  localparam int unsigned PRE_W = (US_CYCLES > 1) ? $clog2(US_CYCLES) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(US_CYCLES - 1);

  // Address decode used by both read and write paths
  function automatic logic addr_is(input logic [3:0] a, input logic [3:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  logic in_rise;

  pin_edge_sync u_in_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin_in(trigger_input_pin),
    .rise_pulse(in_rise)
  );

  // Counter state
  sync_status_pkg::word_t in_tally_reg, in_tally_next;
  sync_status_pkg::word_t out_tally_reg, out_tally_next;
  sync_status_pkg::word_t since_us_reg, since_us_next;
  logic [PRE_W-1:0] pre_reg, pre_next;
  logic trig_out_next;

  always_comb begin
    in_tally_next = in_tally_reg;
    out_tally_next = out_tally_reg;
    since_us_next = since_us_reg;
    pre_next = pre_reg;
    // A same-cycle event counts after the clear, leaving the tally at one, so no trigger is lost
    if (reg_wr && addr_is(reg_addr, `INPUT_EVENT_TALLY_OFS) && reg_wdata == `COUNT_ZERO) begin
      in_tally_next = `COUNT_ZERO;
    end
    if (in_rise) begin
      in_tally_next = in_tally_next + 32'h0000_0001;
    end
    if (reg_wr && addr_is(reg_addr, `OUTPUT_EVENT_TALLY_OFS) && reg_wdata == `COUNT_ZERO) begin
      out_tally_next = `COUNT_ZERO;
    end
    if (out_event_fire) begin
      out_tally_next = out_tally_next + 32'h0000_0001;
    end
    // Elapsed time ignores every write; only a trigger restarts it
    if (in_rise) begin
      since_us_next = `COUNT_ZERO;
      pre_next = '0;
    end else if (pre_reg == PRE_LAST) begin
      pre_next = '0;
      // Saturating would hide wraps; a free wrap matches the tallies
      since_us_next = since_us_reg + 32'h0000_0001;
    end else begin
      pre_next = pre_reg + PRE_W'(1);
    end
    trig_out_next = out_event_fire;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_tally_reg <= `COUNT_ZERO;
      out_tally_reg <= `COUNT_ZERO;
      since_us_reg <= `COUNT_ZERO;
      pre_reg <= '0;
      trigger_output_pin <= 1'b0;
    end else begin
      in_tally_reg <= in_tally_next;
      out_tally_reg <= out_tally_next;
      since_us_reg <= since_us_next;
      pre_reg <= pre_next;
      trigger_output_pin <= trig_out_next;
    end
  end

  // Register read
  logic [31:0] rdata_next;
  logic rvalid_next;

  always_comb begin
    rdata_next = `COUNT_ZERO;
    rvalid_next = reg_rd;
    if (reg_rd) begin
      if (addr_is(reg_addr, `INPUT_EVENT_TALLY_OFS)) begin
        rdata_next = in_tally_reg;
      end else if (addr_is(reg_addr, `SINCE_INPUT_EVENT_US_OFS)) begin
        rdata_next = since_us_reg;
      end else if (addr_is(reg_addr, `OUTPUT_EVENT_TALLY_OFS)) begin
        rdata_next = out_tally_reg;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `COUNT_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= rdata_next;
      reg_rvalid <= rvalid_next;
    end
  end

  // Settings, restore and save
  logic append_next;
  logic [15:0] rate_next;
  logic save_next;
  logic flash_append_next;
  logic [15:0] flash_rate_next;

  always_comb begin
    append_next = append_status_flag;
    rate_next = async_rate_hz;
    save_next = 1'b0;
    flash_append_next = flash_append_status;
    flash_rate_next = flash_async_rate;
    // Restore takes priority over a same-cycle settings write
    if (restore_cmd) begin
      append_next = `FACTORY_APPEND_STATUS;
      rate_next = `FACTORY_ASYNC_RATE_HZ;
    end else if (settings_wr) begin
      append_next = append_status_set;
      rate_next = async_rate_set;
    end
    if (save_cmd) begin
      save_next = 1'b1;
      flash_append_next = append_status_flag;
      flash_rate_next = async_rate_hz;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      append_status_flag <= `FACTORY_APPEND_STATUS;
      async_rate_hz <= `FACTORY_ASYNC_RATE_HZ;
      flash_save_pulse <= 1'b0;
      flash_append_status <= `FACTORY_APPEND_STATUS;
      flash_async_rate <= `FACTORY_ASYNC_RATE_HZ;
    end else begin
      append_status_flag <= append_next;
      async_rate_hz <= rate_next;
      flash_save_pulse <= save_next;
      flash_append_status <= flash_append_next;
      flash_async_rate <= flash_rate_next;
    end
  end

  // Packet status stamp
  logic stamp_valid_next;
  logic [31:0] stamp_tally_next;
  logic [31:0] stamp_us_next;

  always_comb begin
    stamp_valid_next = 1'b0;
    stamp_tally_next = stamp_in_tally;
    stamp_us_next = stamp_since_us;
    if (packet_start && append_status_flag) begin
      stamp_valid_next = 1'b1;
      stamp_tally_next = in_tally_reg;
      stamp_us_next = since_us_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stamp_valid <= 1'b0;
      stamp_in_tally <= `COUNT_ZERO;
      stamp_since_us <= `COUNT_ZERO;
    end else begin
      stamp_valid <= stamp_valid_next;
      stamp_in_tally <= stamp_tally_next;
      stamp_since_us <= stamp_us_next;
    end
  end
endmodule : sync_event_status_counters

// ### rtl/sync_status_regs.svh
// Register offsets, timing and default constants for the sync event status counters
`ifndef SYNC_STATUS_REGS_SVH
`define SYNC_STATUS_REGS_SVH
`define INPUT_EVENT_TALLY_OFS 4'h0
`define SINCE_INPUT_EVENT_US_OFS 4'h4
`define OUTPUT_EVENT_TALLY_OFS 4'h8
`define CLK_FREQ_HZ 100000000
`define US_PER_S 1000000
`define CYCLES_PER_US (`CLK_FREQ_HZ / `US_PER_S)
`define FACTORY_ASYNC_RATE_HZ 16'h0028
`define FACTORY_APPEND_STATUS 1'b0
`define COUNT_ZERO 32'h0000_0000
`endif

// ### rtl/sync_status_pkg.sv
// Types shared by the sync event status counters
package sync_status_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic [1:0] {
    tag_input_tally,
    tag_since_us,
    tag_output_tally
  } status_tag_e;
endpackage : sync_status_pkg

// ### rtl/pin_edge_sync.sv
// Three-stage pin synchroniser with rising-edge pulse
`timescale 1ns/100ps
module pin_edge_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Pin and result
  input wire logic pin_in,
  output logic rise_pulse
);
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic level_reg;
  logic level_next;
  logic rise_next;

  always_comb begin
    stage_next = {stage_reg[1:0], pin_in};
    level_next = level_reg;
    // Only stages two and three are looked at; stage one may be metastable
    if (stage_reg[1] == stage_reg[2]) begin
      level_next = stage_reg[2];
    end
    rise_next = level_next & ~level_reg;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_reg <= 3'h0;
      level_reg <= 1'b0;
      rise_pulse <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
      rise_pulse <= rise_next;
    end
  end
endmodule : pin_edge_sync

// ### dv/sync_event_status_counters_monitor.sv
// Port checker for the sync event status counters
`timescale 1ns/100ps
module sync_event_status_counters_monitor #(
  parameter int unsigned CLK_HZ = 100000000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Watched ports
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire logic [31:0] reg_rdata,
  input wire logic out_event_fire,
  input wire logic trigger_output_pin,
  input wire logic packet_start,
  input wire logic append_status_flag,
  input wire logic stamp_valid,
  input wire logic [31:0] stamp_in_tally,
  input wire logic restore_cmd,
  input wire logic save_cmd,
  input wire logic flash_save_pulse,
  input wire logic [15:0] async_rate_hz,
  input wire logic [15:0] flash_async_rate
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  read_answer_a:
    assert property (reg_rd |=> reg_rvalid) else $error("read unanswered");
  idle_rdata_a:
    assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 32'h0) else $error("stray rdata");
  out_pin_a:
    assert property (trigger_output_pin == $past(out_event_fire)) else $error("out pin wrong");
  stamp_go_a:
    assert property (packet_start && append_status_flag |=> stamp_valid) else $error("no stamp");
  stamp_cause_a:
    assert property (stamp_valid |-> $past(packet_start) && $past(append_status_flag))
      else $error("stray stamp");
  stamp_hold_a:
    assert property ($changed(stamp_in_tally) |-> stamp_valid) else $error("stamp moved");
  restore_rate_a:
    assert property (restore_cmd |=> async_rate_hz == 16'h0028 && !append_status_flag)
      else $error("restore wrong");
  save_copy_a:
    assert property (save_cmd |=> flash_save_pulse && flash_async_rate == $past(async_rate_hz))
      else $error("save wrong");
endmodule : sync_event_status_counters_monitor
bind sync_event_status_counters sync_event_status_counters_monitor
  #(.CLK_HZ(CLK_HZ)) mon_inst (
  .sys_clk(sys_clk), .rst_b(rst_b),
  .reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
  .out_event_fire(out_event_fire), .trigger_output_pin(trigger_output_pin),
  .packet_start(packet_start), .append_status_flag(append_status_flag),
  .stamp_valid(stamp_valid), .stamp_in_tally(stamp_in_tally),
  .restore_cmd(restore_cmd), .save_cmd(save_cmd), .flash_save_pulse(flash_save_pulse),
  .async_rate_hz(async_rate_hz), .flash_async_rate(flash_async_rate)
);

// ### dv/trigger_source.sv
// External trigger source model driving the trigger input pin
`timescale 1ns/100ps
module trigger_source (
  // Clock and request
  input wire logic sys_clk,
  input wire logic fire,
  input wire logic [3:0] width,
  // Pin
  output logic pin
);
  logic [3:0] hold_reg = 4'h0;
  // Pulse length varies so a long pulse must still count once
  // Widths below two cycles are filtered by the pin synchroniser
  always @(posedge sys_clk) begin
    hold_reg <= fire ? width : ((hold_reg == 4'h0) ? 4'h0 : hold_reg - 4'h1);
  end
  assign pin = (hold_reg != 4'h0);
endmodule : trigger_source

// ### dv/tb_sync_event_status_counters.sv
// Testbench for the sync event status counters
`timescale 1ns/100ps
`include "sync_status_regs.svh"
module tb_sync_event_status_counters;
  logic sys_clk = 1'b0, rst_b = 1'b0, trig_fire = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic out_event_fire = 1'b0, settings_wr = 1'b0, restore_cmd = 1'b0, save_cmd = 1'b0;
  logic append_status_set = 1'b0, packet_start = 1'b0;
  logic [3:0] trig_len = 4'h1, reg_addr = 4'h0;
  logic [15:0] async_rate_set = 16'h0, async_rate_hz, flash_async_rate;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, stamp_in_tally, stamp_since_us, v;
  logic trigger_input_pin, trigger_output_pin, reg_rvalid, append_status_flag;
  logic flash_save_pulse, flash_append_status, stamp_valid;
  int fails = 0;
  int checked = 0;
  always #5 sys_clk = ~sys_clk;
  trigger_source trigger_source_inst (.sys_clk(sys_clk), .fire(trig_fire), .width(trig_len),
    .pin(trigger_input_pin));
  sync_event_status_counters #(.CLK_HZ(1000000)) sync_event_status_counters_inst (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .trigger_input_pin(trigger_input_pin), .out_event_fire(out_event_fire),
    .trigger_output_pin(trigger_output_pin),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .append_status_set(append_status_set), .async_rate_set(async_rate_set),
    .settings_wr(settings_wr), .restore_cmd(restore_cmd), .save_cmd(save_cmd),
    .append_status_flag(append_status_flag), .async_rate_hz(async_rate_hz),
    .flash_save_pulse(flash_save_pulse), .flash_append_status(flash_append_status),
    .flash_async_rate(flash_async_rate),
    .packet_start(packet_start), .stamp_valid(stamp_valid),
    .stamp_in_tally(stamp_in_tally), .stamp_since_us(stamp_since_us)
  );
  task automatic report_and_stop;
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_rd = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    d = reg_rdata;
    chk("reg_rvalid", 32'h1, {31'h0, reg_rvalid});
    tick(1);
  endtask : rd
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    rd(a, v);
    chk($sformatf("reg %h", a), exp, v);
  endtask : rdc
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask : wr
  task automatic trig(input logic [3:0] n);
    trig_fire = 1'b1;
    trig_len = n;
    tick(1);
    trig_fire = 1'b0;
    tick(12);
  endtask : trig
  initial begin
    #100000;
    fails++;
    report_and_stop;
  end
  initial begin
    tick(12);
    rst_b = 1'b1;
    tick(1);
    rdc(4'h0, 32'h0);
    rdc(4'hc, 32'h0);
    chk("async_rate_hz", {16'h0, `FACTORY_ASYNC_RATE_HZ}, {16'h0, async_rate_hz});
    // A one-cycle pin pulse never shows equal in sync stages two and three
    trig(4'h2);
    trig(4'h4);
    trig(4'h2);
    rdc(4'h0, 32'h3);
    wr(4'h0, 32'h5);
    rdc(4'h0, 32'h3);
    wr(4'h0, 32'h0);
    rdc(4'h0, 32'h0);
    out_event_fire = 1'b1;
    tick(2);
    out_event_fire = 1'b0;
    tick(1);
    rdc(4'h8, 32'h2);
    wr(4'h8, 32'h0);
    rdc(4'h8, 32'h0);
    trig(4'h2);
    rd(4'h4, v);
    chk("since_small", 32'h1, {31'h0, v < 32'h20});
    wr(4'h4, 32'h0);
    rdc(4'h4, v + 32'h4);
    async_rate_set = 16'h0064;
    append_status_set = 1'b1;
    settings_wr = 1'b1;
    tick(1);
    settings_wr = 1'b0;
    trig(4'h3);
    packet_start = 1'b1;
    tick(1);
    packet_start = 1'b0;
    chk("stamp_valid", 32'h1, {31'h0, stamp_valid});
    chk("stamp_in_tally", 32'h2, stamp_in_tally);
    chk("stamp_since", 32'h1, {31'h0, stamp_since_us < 32'h20});
    save_cmd = 1'b1;
    tick(1);
    save_cmd = 1'b0;
    chk("flash_async_rate", 32'h64, {16'h0, flash_async_rate});
    chk("flash_save_pulse", 32'h1, {31'h0, flash_save_pulse});
    chk("flash_append_status", 32'h1, {31'h0, flash_append_status});
    restore_cmd = 1'b1;
    tick(1);
    restore_cmd = 1'b0;
    chk("async_rate_hz", 32'h28, {16'h0, async_rate_hz});
    chk("append_status_flag", 32'h0, {31'h0, append_status_flag});
    packet_start = 1'b1;
    tick(1);
    packet_start = 1'b0;
    chk("stamp_valid_off", 32'h0, {31'h0, stamp_valid});
    chk("stamp_in_tally_held", 32'h2, stamp_in_tally);
    report_and_stop;
  end
endmodule : tb_sync_event_status_counters
